// File: design/spoc_params.svh
// Constants of the serial port open/close control block: register
// offsets, field positions, reset values and counts.
// Assumes inclusion by bare name from the package and the modules.
`ifndef SPOC_PARAMS_SVH
`define SPOC_PARAMS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define SPOC_NPORT 4
`define SPOC_FIFO_DEPTH 8

// ------------------------------------------------------------
// Register byte offsets (haddr[7:0]) and the config page (haddr[7:4])
// ------------------------------------------------------------
`define SPOC_OFS_CMD 8'h00
`define SPOC_OFS_STAT 8'h04
`define SPOC_OFS_TXDATA 8'h08
`define SPOC_OFS_RXDATA 8'h0c
`define SPOC_OFS_RXSEL 8'h10
`define SPOC_PCFG_PAGE 4'h2

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SPOC_CMD_OP_LSB 0
`define SPOC_CMD_SEL_LSB 2
`define SPOC_CMD_ARG_LSB 8
`define SPOC_CMD_DIV_LSB 16
`define SPOC_TX_SEL_LSB 8
`define SPOC_STAT_EN_LSB 4
`define SPOC_RX_VALID_BIT 8

// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define SPOC_BRK_RST 8'h00
`define SPOC_MODE_RST 8'h00
`define SPOC_DIV_RST 16'h0364
`define SPOC_FRAME_LAST 4'h9
`define SPOC_RX_LAST 4'h8

`endif

// File: design/spoc_pkg.sv
// Types shared by the serial port open/close control block.
// Assumes spoc_params.svh is on the include path.
package spoc_pkg;
   `include "spoc_params.svh"

   typedef enum logic [1:0] {
      SPOC_OP_MODE = 2'b00,
      SPOC_OP_BRK = 2'b01,
      SPOC_OP_EN = 2'b10,
      SPOC_OP_DIS = 2'b11
   } spoc_op_e;

   typedef enum logic [1:0] {
      SPOC_RX_IDLE = 2'b00,
      SPOC_RX_START = 2'b01,
      SPOC_RX_DATA = 2'b10,
      SPOC_RX_HOLD = 2'b11
   } spoc_rxst_e;

   typedef struct packed {
      logic [15:0] div;
      logic [7:0] brk;
      logic [7:0] mode;
   } spoc_pcfg_s;

   typedef struct packed {
      logic busy;
      logic line;
      logic [9:0] sh;
      logic [3:0] bits;
      logic [15:0] cnt;
   } spoc_tx_s;

   typedef struct packed {
      spoc_rxst_e st;
      logic [8:0] sh;
      logic [3:0] bits;
      logic [15:0] cnt;
      logic pv;
      logic [7:0] pb;
   } spoc_rx_s;

   typedef struct packed {
      logic v;
      logic wr;
      logic [7:0] addr;
   } spoc_aphase_s;
endpackage

// File: design/spoc_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to mclk; INIT is the idle level.
`timescale 1ns/1ps
module spoc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } spoc_sync_s;

   spoc_sync_s q, d;

   always_comb begin
      d.s1 = pin;
      d.s2 = q.s1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= {INIT, INIT};
      end else begin
         q <= d;
      end
   end

   assign sync = q.s2;
endmodule

// File: design/spoc_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes one clock; flush wins over a push or pop in the same cycle.
`timescale 1ns/1ps
module spoc_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clr,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);

   generate
      if (D < 2 || (1 << AW) != D) begin : g_bad_depth
         $error("spoc_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } spoc_fifo_s;

   spoc_fifo_s q, d;
   logic push, pop;

   assign in_ready = (q.cnt != AW'(0) + (AW+1)'(D)) ? 1'b1 : 1'b0;
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = q.wp + AW'(1);
      end
      if (pop) begin
         d.rp = q.rp + AW'(1);
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (clr) begin
         d.wp = '0;
         d.rp = '0;
         d.cnt = '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// File: design/spoc_ctrl.sv
// Port command control for four serial ports behind an AHB-Lite slave.
// Assumes a single master, word transfers only, and that rxd pins are
// asynchronous to mclk. Each port carries an 8N1 transmitter and receiver
// whose bit period is the programmed divisor in mclk cycles.
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "spoc_params.svh"

module spoc_ctrl
   import spoc_pkg::*;
#(
   parameter int FIFO_DEPTH = `SPOC_FIFO_DEPTH,
   parameter logic [15:0] DIV_RST = `SPOC_DIV_RST
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic [`SPOC_NPORT-1:0] txd,
   input wire logic [`SPOC_NPORT-1:0] rxd
);
   localparam int NP = `SPOC_NPORT;

   generate
      if (DIV_RST < 16'h0002) begin : g_bad_div
         $error("spoc_ctrl reset divisor must be at least 2");
      end
   endgenerate

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      spoc_aphase_s ap;
      logic [31:0] rdata;
      logic refused;
      logic [1:0] last;
      logic [2:0] rxsel;
      logic [NP-1:0] en;
      spoc_pcfg_s [NP-1:0] cfg;
      spoc_tx_s [NP-1:0] tx;
      spoc_rx_s [NP-1:0] rx;
   } spoc_ctrl_s;

   spoc_ctrl_s q, d;

   logic [NP-1:0] rxs;
   logic [NP-1:0] tf_iv, tf_ir, tf_ov, tf_or;
   logic [NP-1:0] rf_iv, rf_ir, rf_ov, rf_or;
   logic [NP-1:0] clr;
   logic [NP-1:0][7:0] tf_od, rf_od;
   logic [7:0] tf_id;

   // ------------------------------------------------------------
   // Pins and queues
   // ------------------------------------------------------------
   spoc_sync #(
      .W(NP),
      .INIT({NP{1'b1}})
   ) u_rx_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .pin(rxd),
      .sync(rxs)
   );

   generate
      for (genvar p = 0; p < NP; p++) begin : g_port
         spoc_fifo #(
            .W(8),
            .D(FIFO_DEPTH)
         ) u_txq (
            .mclk(mclk),
            .rst_b(rst_b),
            .clr(clr[p]),
            .in_valid(tf_iv[p]),
            .in_data(tf_id),
            .in_ready(tf_ir[p]),
            .out_valid(tf_ov[p]),
            .out_data(tf_od[p]),
            .out_ready(tf_or[p])
         );

         spoc_fifo #(
            .W(8),
            .D(FIFO_DEPTH)
         ) u_rxq (
            .mclk(mclk),
            .rst_b(rst_b),
            .clr(clr[p]),
            .in_valid(rf_iv[p]),
            .in_data(q.rx[p].pb),
            .in_ready(rf_ir[p]),
            .out_valid(rf_ov[p]),
            .out_data(rf_od[p]),
            .out_ready(rf_or[p])
         );

         // A received byte is dropped when the port is closed or the queue is full.
         assign rf_iv[p] = q.rx[p].pv && q.en[p];
         assign txd[p] = q.tx[p].line;
      end
   endgenerate

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign tf_id = hwdata[7:0];

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [2:0] sel;
      logic [1:0] idx;
      logic ok;
      logic take;
      logic [7:0] a;
      spoc_tx_s t;
      spoc_rx_s r;
      logic [8:0] nsh;
      d = q;
      tf_iv = '0;
      tf_or = '0;
      rf_or = '0;
      clr = '0;
      sel = '0;
      idx = '0;
      ok = 1'b0;
      t = '0;
      r = '0;
      nsh = '0;
      a = haddr[7:0];
      take = hsel && hready && htrans[1];

      // Data phase of a write: commands act here.
      if (q.ap.v && q.ap.wr) begin
         unique case (q.ap.addr)
            `SPOC_OFS_CMD: begin
               sel = hwdata[`SPOC_CMD_SEL_LSB +: 3];
               ok = (sel >= 3'd1) && (sel <= 3'(NP));
               idx = 2'(sel - 3'd1);
               d.refused = 1'b0;
               if (ok) begin
                  d.last = idx;
               end
               unique case (spoc_op_e'(hwdata[`SPOC_CMD_OP_LSB +: 2]))
                  SPOC_OP_MODE: begin
                     // A zero divisor would wrap to a 65536-cycle bit period in both engines, so it is refused too.
                     if (!ok || q.en[idx] || hwdata[`SPOC_CMD_DIV_LSB +: 16] == 16'h0000) begin
                        d.refused = 1'b1;
                     end else begin
                        d.cfg[idx].div = hwdata[`SPOC_CMD_DIV_LSB +: 16];
                        d.cfg[idx].mode = hwdata[`SPOC_CMD_ARG_LSB +: 8];
                     end
                  end
                  SPOC_OP_BRK: begin
                     if (!ok) begin
                        d.refused = 1'b1;
                     end else begin
                        d.cfg[idx].brk = hwdata[`SPOC_CMD_ARG_LSB +: 8];
                     end
                  end
                  SPOC_OP_EN: begin
                     if (!ok || q.en[idx]) begin
                        d.refused = 1'b1;
                     end else begin
                        d.en[idx] = 1'b1;
                     end
                  end
                  SPOC_OP_DIS: begin
                     if (!ok || !q.en[idx]) begin
                        d.refused = 1'b1;
                     end else begin
                        d.en[idx] = 1'b0;
                        clr[idx] = 1'b1;
                     end
                  end
               endcase
            end
            `SPOC_OFS_TXDATA: begin
               sel = hwdata[`SPOC_TX_SEL_LSB +: 3];
               ok = (sel >= 3'd1) && (sel <= 3'(NP));
               idx = 2'(sel - 3'd1);
               d.refused = 1'b0;
               // Back-pressure from a full queue shows as a refused send.
               if (!ok || !q.en[idx] || !tf_ir[idx]) begin
                  d.refused = 1'b1;
               end else begin
                  d.last = idx;
                  tf_iv[idx] = 1'b1;
               end
            end
            `SPOC_OFS_RXSEL: begin
               d.rxsel = hwdata[2:0];
            end
            default: begin
            end
         endcase
      end

      // Address phase: reads are answered from the current state.
      d.ap.v = take;
      d.ap.wr = hwrite && (hsize == 3'b010);
      d.ap.addr = a;
      if (take && !hwrite) begin
         d.rdata = '0;
         if (a == `SPOC_OFS_STAT) begin
            d.rdata[0] = q.refused;
            d.rdata[1] = q.en[q.last];
            d.rdata[`SPOC_STAT_EN_LSB +: NP] = q.en;
         end else if (a == `SPOC_OFS_RXSEL) begin
            d.rdata[2:0] = q.rxsel;
         end else if (a == `SPOC_OFS_RXDATA) begin
            sel = q.rxsel;
            ok = (sel >= 3'd1) && (sel <= 3'(NP));
            idx = 2'(sel - 3'd1);
            if (ok && q.en[idx] && rf_ov[idx]) begin
               d.rdata[`SPOC_RX_VALID_BIT] = 1'b1;
               d.rdata[7:0] = rf_od[idx];
               rf_or[idx] = 1'b1;
            end
         end else if (a[7:4] == `SPOC_PCFG_PAGE) begin
            d.rdata = q.cfg[a[3:2]];
         end
      end

      // Serial engines, one per port.
      for (int p = 0; p < NP; p++) begin
         t = q.tx[p];
         if (t.busy) begin
            // The frame in flight runs out even after the port closes.
            if (t.cnt != 16'h0000) begin
               t.cnt = t.cnt - 16'h0001;
            end else if (t.bits == `SPOC_FRAME_LAST) begin
               t.busy = 1'b0;
               t.line = 1'b1;
            end else begin
               t.sh = {1'b1, t.sh[9:1]};
               t.line = t.sh[0];
               t.bits = t.bits + 4'h1;
               t.cnt = q.cfg[p].div - 16'h0001;
            end
         end else if (q.en[p] && tf_ov[p] && !clr[p]) begin
            tf_or[p] = 1'b1;
            t.busy = 1'b1;
            t.sh = {1'b1, tf_od[p], 1'b0};
            t.line = 1'b0;
            t.bits = 4'h0;
            t.cnt = q.cfg[p].div - 16'h0001;
         end
         d.tx[p] = t;

         r = q.rx[p];
         r.pv = 1'b0;
         nsh = {rxs[p], r.sh[8:1]};
         unique case (r.st)
            SPOC_RX_IDLE: begin
               if (q.en[p] && !rxs[p]) begin
                  r.st = SPOC_RX_START;
                  r.cnt = {1'b0, q.cfg[p].div[15:1]};
               end
            end
            SPOC_RX_START: begin
               if (r.cnt != 16'h0000) begin
                  r.cnt = r.cnt - 16'h0001;
               end else if (rxs[p]) begin
                  r.st = SPOC_RX_IDLE;
               end else begin
                  r.st = SPOC_RX_DATA;
                  r.bits = 4'h0;
                  r.cnt = q.cfg[p].div - 16'h0001;
               end
            end
            SPOC_RX_DATA: begin
               if (r.cnt != 16'h0000) begin
                  r.cnt = r.cnt - 16'h0001;
               end else begin
                  r.sh = nsh;
                  r.bits = r.bits + 4'h1;
                  r.cnt = q.cfg[p].div - 16'h0001;
                  if (r.bits == `SPOC_RX_LAST + 4'h1) begin
                     if (nsh[8]) begin
                        r.pv = 1'b1;
                        r.pb = nsh[7:0];
                        r.st = SPOC_RX_IDLE;
                     end else begin
                        // A low stop bit with all-zero data is a break.
                        r.pv = (nsh[7:0] == 8'h00);
                        r.pb = q.cfg[p].brk;
                        r.st = SPOC_RX_HOLD;
                     end
                  end
               end
            end
            SPOC_RX_HOLD: begin
               if (rxs[p]) begin
                  r.st = SPOC_RX_IDLE;
               end
            end
         endcase
         if (!q.en[p]) begin
            r.st = SPOC_RX_IDLE;
         end
         d.rx[p] = r;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         for (int p = 0; p < NP; p++) begin
            q.cfg[p].div <= DIV_RST;
            q.cfg[p].brk <= `SPOC_BRK_RST;
            q.cfg[p].mode <= `SPOC_MODE_RST;
            q.tx[p].line <= 1'b1;
         end
      end else begin
         q <= d;
      end
   end
endmodule

// File: bench/spoc_remote.sv
// Remote serial device model facing the four ports of the command block.
// Assumes the bench keeps div equal to the divisor set in the ports.
`timescale 1ns/1ps
module spoc_remote (
   input wire logic mclk,
   input wire logic [3:0] txd,
   output logic [3:0] rxd
);
   int div = 16;
   logic [7:0] got [4][$];

   // Idle lines sit at mark level, as a released line would.
   initial rxd = 4'hf;

   // A break is ten low bit times: start, eight zero bits and a low stop.
   task automatic send(input int p, input logic [7:0] b, input logic brk);
      logic [9:0] f;
      f = {~brk, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd[p] <= f[i];
         repeat (div) @(posedge mclk);
      end
      rxd[p] <= 1'b1;
      repeat (2 * div) @(posedge mclk);
   endtask

   for (genvar g = 0; g < 4; g++) begin : g_mon
      initial forever begin
         logic [7:0] b;
         @(negedge txd[g]);
         repeat (div / 2) @(posedge mclk);
         for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge mclk);
            b[i] = txd[g];
         end
         repeat (div) @(posedge mclk);
         got[g].push_back(b);
      end
   end
endmodule

// File: bench/spoc_ctrl_sva.sv
// Assertions on the port command block, seen from its bus and serial pins.
// Assumes one master; a shadow of the port enables is kept from the writes.
`timescale 1ns/1ps
`include "spoc_params.svh"
module spoc_ctrl_sva
   import spoc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic [`SPOC_NPORT-1:0] txd
);
   typedef struct packed {
      logic cmd;
      logic [3:0] en;
      logic pre;
      logic [1:0] op;
      logic known;
      logic refd;
   } spoc_sh_s;
   spoc_sh_s sh_q, sh_d, sn_q;
   logic rd_q, take, sel_ok, refuse;
   logic [2:0] sel;
   logic [1:0] pi;

   always_comb begin
      take = hsel && hready && htrans[1];
      sel = hwdata[4:2];
      pi = 2'(sel - 3'd1);
      sel_ok = sel >= 3'd1 && sel <= 3'd4;
      refuse = !sel_ok;
      sh_d = sh_q;
      sh_d.cmd = take && hwrite && hsize == 3'b010 && haddr[7:0] == `SPOC_OFS_CMD;
      if (sh_q.cmd) begin
         case (hwdata[1:0])
            SPOC_OP_MODE: refuse = !sel_ok || sh_q.en[pi] || hwdata[31:16] == 16'h0000;
            SPOC_OP_EN: refuse = !sel_ok || sh_q.en[pi];
            SPOC_OP_DIS: refuse = !sel_ok || !sh_q.en[pi];
            default: refuse = !sel_ok;
         endcase
         sh_d.pre = sh_q.en[pi];
         sh_d.op = hwdata[1:0];
         sh_d.known = sel_ok;
         sh_d.refd = refuse;
         if (!refuse && hwdata[1:0] == SPOC_OP_EN) begin
            sh_d.en[pi] = 1'b1;
         end
         if (!refuse && hwdata[1:0] == SPOC_OP_DIS) begin
            sh_d.en[pi] = 1'b0;
         end
      end
      // A data write also rewrites the refused flag, so the outcome is unknown here.
      if (take && hwrite && haddr[7:0] == `SPOC_OFS_TXDATA) begin
         sh_d.known = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sh_q <= '0;
         sn_q <= '0;
         rd_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         sn_q <= sh_q;
         rd_q <= take && !hwrite && haddr[7:0] == `SPOC_OFS_STAT;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or response not okay");
   a_txd_reset_idle: assert property (!$past(rst_b) |-> txd == '1)
      else $error("serial line not idle after reset");
   a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
   a_stat_en_live: assert property (rd_q |-> hrdata[7:4] == sn_q.en)
      else $error("enabled flags differ from commands");
   a_mode_refused: assert property (rd_q && sn_q.known && sn_q.op == SPOC_OP_MODE
      && sn_q.pre |-> hrdata[0])
      else $error("mode set on enabled port not refused");
   a_brk_taken: assert property (rd_q && sn_q.known && sn_q.op == SPOC_OP_BRK
      |-> !hrdata[0])
      else $error("break fill command refused");
   a_open_twice: assert property (rd_q && sn_q.known && sn_q.op == SPOC_OP_EN
      && sn_q.pre |-> hrdata[0])
      else $error("second enable not refused");
   a_open_flag: assert property (rd_q && sn_q.known && sn_q.op == SPOC_OP_EN
      && !sn_q.pre |-> hrdata[1:0] == 2'b10)
      else $error("enable status wrong");
   a_close_twice: assert property (rd_q && sn_q.known && sn_q.op == SPOC_OP_DIS
      && !sn_q.pre |-> hrdata[0])
      else $error("second disable not refused");
   a_close_flag: assert property (rd_q && sn_q.known && sn_q.op == SPOC_OP_DIS
      && sn_q.pre |-> hrdata[1:0] == 2'b00)
      else $error("disable status wrong");
   a_refused_fresh: assert property (rd_q && sn_q.known && !sn_q.refd |-> !hrdata[0])
      else $error("refused flag left over");

   c_open: cover property (rd_q && sn_q.known && sn_q.op == SPOC_OP_EN && !sn_q.pre);
   c_close: cover property (rd_q && sn_q.known && sn_q.op == SPOC_OP_DIS && sn_q.pre);
   c_mode_refused: cover property (rd_q && sn_q.op == SPOC_OP_MODE && sn_q.refd);
endmodule

bind spoc_ctrl spoc_ctrl_sva u_sva (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .txd(txd));

// File: bench/spoc_ctrl_tb.sv
// Self-checking bench for the port command block and its remote device.
// Assumes the checker is bound in and the remote model drives rxd.
`timescale 1ns/1ps
`include "spoc_params.svh"
module spoc_ctrl_tb import spoc_pkg::*; ;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = '0;
   logic hready, hreadyout, hresp;
   logic [31:0] hrdata, rd;
   logic [3:0] txd, rxd;
   logic [3:0] en_m = '0;
   logic [31:0] cfg_m [4];
   int fails = 0;
   int checks = 0;
   int lp = 1;

   always #5 mclk = ~mclk;
   assign hready = hreadyout;

   spoc_ctrl dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .txd(txd), .rxd(rxd));
   spoc_remote rem (.mclk(mclk), .txd(txd), .rxd(rxd));

   // ------------------------------------------------------------
   // Bus and checking tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   function automatic logic f_ref(input int op, input int p, input logic [3:0] en,
      input int dv);
      if (p < 1 || p > 4) return 1'b1;
      case (op)
         0: return en[p-1] || dv == 0;
         2: return en[p-1];
         3: return !en[p-1];
         default: return 1'b0;
      endcase
   endfunction

   // Every command is followed by a status read, checked against the shadow.
   task automatic cmd(input int op, input int p, input logic [7:0] arg, input int dv);
      logic r;
      r = f_ref(op, p, en_m, dv);
      bus(1'b1, `SPOC_OFS_CMD, {16'(dv), arg, 3'b000, 3'(p), 2'(op)});
      if (!r && op == 2) en_m[p-1] = 1'b1;
      if (!r && op == 3) en_m[p-1] = 1'b0;
      if (!r && op == 0) cfg_m[p-1] = {16'(dv), cfg_m[p-1][15:8], arg};
      if (!r && op == 1) cfg_m[p-1][15:8] = arg;
      if (p >= 1 && p <= 4) lp = p;
      bus(1'b0, `SPOC_OFS_STAT, '0);
      chk("status", {24'h0, en_m, 2'b00, en_m[lp-1], r}, rd);
   endtask

   // Every reset release is followed by the same look at status and port settings.
   task automatic after_reset();
      rst_b <= 1'b1;
      @(posedge mclk);
      en_m = '0;
      lp = 1;
      cfg_m = '{default: {`SPOC_DIV_RST, 16'h0000}};
      bus(1'b0, `SPOC_OFS_STAT, '0);
      chk("status", 32'h0, rd);
      for (int p = 0; p < 4; p++) begin
         bus(1'b0, {`SPOC_PCFG_PAGE, 2'(p), 2'b00}, '0);
         chk("config", cfg_m[p], rd);
      end
   endtask

   task automatic wrap_up();
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] rxq [4];
      logic [7:0] tx_b [10];
      rxq = '{32'h100, 32'h1a5, 32'h13c, 32'h0};
      void'($urandom(32'h55fa));
      repeat (6) @(posedge mclk);
      after_reset();
      bus(1'b0, 8'h3c, '0);
      chk("unmapped", 32'h0, rd);
      cmd(0, 1, 8'h00, 16);
      cmd(2, 1, 8'h00, 0);
      cmd(2, 1, 8'h00, 0);
      cmd(0, 1, 8'h11, 16);
      bus(1'b1, `SPOC_OFS_RXSEL, 32'h1);
      bus(1'b0, `SPOC_OFS_RXSEL, '0);
      chk("rx select", 32'h1, rd);
      rem.send(0, 8'h00, 1'b1);
      cmd(1, 1, 8'ha5, 0);
      rem.send(0, 8'h00, 1'b1);
      rem.send(0, 8'h3c, 1'b0);
      // A low stop bit under nonzero data is a framing fault, not a break.
      rem.send(0, 8'h5a, 1'b1);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, `SPOC_OFS_RXDATA, '0);
         chk("rx byte", rxq[i], rd);
      end
      // The first byte leaves at once, so nine fit and the tenth is refused.
      cmd(0, 3, 8'h00, 16);
      cmd(2, 3, 8'h00, 0);
      for (int i = 0; i < 10; i++) begin
         tx_b[i] = 8'($urandom);
         bus(1'b1, `SPOC_OFS_TXDATA, {21'h0, 3'd3, tx_b[i]});
         bus(1'b0, `SPOC_OFS_STAT, '0);
         chk("tx refused", 32'(i == 9), rd & 32'h1);
      end
      for (int n = 0; n < 3000 && rem.got[2].size() < 9; n++) @(posedge mclk);
      chk("tx count", 32'd9, 32'(rem.got[2].size()));
      for (int i = 0; i < 9; i++) chk("tx byte", 32'(tx_b[i]), 32'(rem.got[2][i]));
      rem.send(0, 8'h77, 1'b0);
      bus(1'b1, `SPOC_OFS_TXDATA, 32'h181);
      bus(1'b1, `SPOC_OFS_TXDATA, 32'h142);
      for (int n = 0; n < 100 && txd[0] !== 1'b0; n++) @(posedge mclk);
      repeat (48) @(posedge mclk);
      cmd(3, 1, 8'h00, 0);
      repeat (400) @(posedge mclk);
      chk("tx count", 32'd1, 32'(rem.got[0].size()));
      chk("tx byte", 32'h81, 32'(rem.got[0][0]));
      cmd(2, 1, 8'h00, 0);
      bus(1'b0, `SPOC_OFS_RXDATA, '0);
      chk("rx flushed", 32'h0, rd);
      cmd(3, 1, 8'h00, 0);
      cmd(3, 1, 8'h00, 0);
      for (int i = 0; i < 30; i++) begin
         cmd($urandom % 4, $urandom % 6, 8'($urandom), $urandom % 3 * 16);
      end
      for (int p = 0; p < 4; p++) begin
         bus(1'b0, {`SPOC_PCFG_PAGE, 2'(p), 2'b00}, '0);
         chk("config", cfg_m[p], rd);
      end
      // A second reset in mid-run must close every port and restore its settings.
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      after_reset();
      cmd(3, 2, 8'h00, 0);
      wrap_up();
   end
endmodule
